/* core/buck_gate_and_fault_supervisor.sv */
// Gate sequencing and fault supervisor for a two-channel buck controller
// Summary of operation
// RULE_01 - About 20 ns with both switches off before the other switch turns on.
// RULE_02 - At start-up low side turns on first; high side only after it is off.
// RULE_03 - Bootstrap low while not switching issues one minimum off-time pulse.
// RULE_04 - Power-good rises after channel 1 feedback stays in window 1.1 ms.
// RULE_05 - Power-good drops when channel 1 leaves its window or enable is low.
// RULE_06 - Power-good drop has no qualification delay.
// RULE_07 - Input undervoltage holds the controller in reset, disabled.
// RULE_08 - During undervoltage, power-good stays driven low.
// RULE_09 - Regulated rail ready above 4 V, failed below 3.5 V, with hysteresis.
// RULE_10 - Overcurrent mode is sampled once during initialisation and latched.
// RULE_11 - Mode pin below 0.3 V selects constant current, else hiccup.
// RULE_12 - Hiccup mode: 32 cycles over average limit stops switching 55 ms.
// RULE_13 - First peak limit ends the present high-side pulse on either channel.
// RULE_14 - First peak limit never cuts a pulse below the blanking time.
// RULE_15 - Second peak limit turns all switches off 55 ms, then restarts; code turns off only the two switches of the tripping channel.
// RULE_16 - Negative peak limit turns low side off, high side on for that cycle.
// RULE_17 - Overvoltage means output above 114 percent of nominal.
// RULE_18 - Overvoltage holds high side off, low side on, save negative limit.
// RULE_19 - Overvoltage cleared and output nominal again resumes normal PWM.
// RULE_20 - Overvoltage flag output is high while overvoltage protection trips.
// RULE_21 - Comparator inputs are synchronised; hiccup time counted in clocks.
// RULE_22 - Hiccup restart re-enters initialisation with both switches off.
`timescale 1ns/1ns
module buck_gate_and_fault_supervisor #(
	parameter int HICCUP_CYCLES = buck_pkg::HICCUP_CYC,
	parameter int PG_CYCLES = buck_pkg::PG_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Comparator results
	input buck_pkg::glob_cmp_s glob_in,
	input buck_pkg::chan_cmp_s [1:0] chan_in,
	// Switch drives, index 0 is channel 1
	output logic [1:0] upper_switch_drive,
	output logic [1:0] lower_switch_drive,
	// Status
	output logic power_good_out,
	output logic excess_output_flag,
	output logic ocp_hiccup_mode
);

	// Two-stage synchronisers for every comparator input
	// Logic reads only the second stage, never the first
	buck_pkg::glob_cmp_s gs1_q, gs2_q;
	buck_pkg::chan_cmp_s [1:0] cs1_q, cs2_q;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gs1_q <= '0;
			gs2_q <= '0;
			cs1_q <= '0;
			cs2_q <= '0;
		end
		else
		begin
			gs1_q <= glob_in; // see RULE_21
			gs2_q <= gs1_q;
			cs1_q <= chan_in;
			cs2_q <= cs1_q;
		end
	end

	// Rail hysteresis, mode latch and power-good
	logic por_q, por_d, smp_q, smp_d, hic_q, hic_d, pg_q, pg_d, ready;
	logic [31:0] pgc_q, pgc_d;
	logic [1:0] in_init, ov_w;
	always_comb
	begin
		por_d = por_q;
		if (gs2_q.rail_above_4v)
			por_d = 1'b1; // see RULE_09
		else if (!gs2_q.rail_above_3v5)
			por_d = 1'b0; // see RULE_09
		// Mode latch re-arms only when the supply drops out
		smp_d = smp_q;
		hic_d = hic_q;
		if (!ready)
			smp_d = 1'b0;
		else if (|in_init && !smp_q)
		begin
			smp_d = 1'b1; // see RULE_10
			hic_d = !gs2_q.lowside2_current_mode_pin; // see RULE_11
		end
		// Qualification count; any drop clears at once
		pg_d = pg_q;
		pgc_d = pgc_q;
		if (!gs2_q.ch1_feedback || !gs2_q.ch1_enable_in || !ready)
		begin
			pg_d = 1'b0; // see RULE_05 RULE_06 RULE_08
			pgc_d = 32'h0000_0000;
		end
		else if (pgc_q == 32'(PG_CYCLES - 1))
			pg_d = 1'b1; // see RULE_04
		else
			pgc_d = pgc_q + 32'h0000_0001;
	end

	// Ready only with the rail up and no input undervoltage
	assign ready = por_q && !gs2_q.input_undervolt_lockout; // see RULE_07

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			por_q <= 1'b0;
			smp_q <= 1'b0;
			hic_q <= buck_pkg::MODE_HIC_RST;
			pg_q <= 1'b0;
			pgc_q <= 32'h0000_0000;
			power_good_out <= 1'b0;
			excess_output_flag <= 1'b0;
			ocp_hiccup_mode <= buck_pkg::MODE_HIC_RST;
		end
		else
		begin
			por_q <= por_d;
			smp_q <= smp_d;
			hic_q <= hic_d;
			pg_q <= pg_d;
			pgc_q <= pgc_d;
			power_good_out <= pg_d;
			excess_output_flag <= |ov_w; // see RULE_20
			ocp_hiccup_mode <= hic_d;
		end
	end

	// One supervisor per channel
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_ch
			buck_pkg::state_e st_q, st_d;
			buck_pkg::chan_cmp_s c;
			logic [31:0] cnt_q, cnt_d;
			logic [7:0] on_q, on_d, ref_q, ref_d;
			logic [3:0] dead_q, dead_d;
			logic [5:0] avg_q, avg_d;
			logic [1:0] out_q, out_d, tgt;
			logic en, pk_q, pk_d, ng_q, ng_d, ov_q, ov_d, hs_want;

			assign c = cs2_q[ch];
			assign en = (ch == 0) ? gs2_q.ch1_enable_in
				: gs2_q.ch2_enable_in;
			assign in_init[ch] = (st_q == buck_pkg::ST_INIT);
			assign ov_w[ch] = ov_q;

			// Sequencing, protections and target gate pattern
			always_comb
			begin
				st_d = st_q;
				cnt_d = cnt_q;
				avg_d = avg_q;
				pk_d = pk_q;
				ng_d = ng_q;
				ov_d = ov_q;
				ref_d = ref_q;
				tgt = 2'h0;
				hs_want = 1'b0;
				// Blanking counter for the high-side pulse
				on_d = out_q[1] ? ((on_q == 8'hff) ? on_q
					: on_q + 8'h01) : 8'h00;
				// Peak cut lasts until the modulator drops its request
				if (!c.pwm_req)
					pk_d = 1'b0;
				else if (out_q[1] && c.first_peak_limit &&
					on_q >= 8'(buck_pkg::MIN_ON_CYC))
					pk_d = 1'b1; // see RULE_13 RULE_14
				// Negative cut lasts for the rest of this cycle;
				// a trip in the tick cycle beats the clear
				if (out_q[0] && c.negative_peak_limit)
					ng_d = 1'b1; // see RULE_16
				else if (gs2_q.cycle_tick)
					ng_d = 1'b0;
				// Overvoltage holds until output is back at nominal
				if (c.over_114)
					ov_d = 1'b1; // see RULE_17
				else if (c.at_nominal)
					ov_d = 1'b0; // see RULE_19
				if (ref_q != 8'h00)
					ref_d = ref_q - 8'h01;
				case (st_q)
					buck_pkg::ST_OFF:
					begin
						cnt_d = 32'h0000_0000;
						st_d = buck_pkg::ST_INIT;
					end
					buck_pkg::ST_INIT:
					begin
						cnt_d = 32'h0000_0000;
						st_d = buck_pkg::ST_PRE;
					end
					buck_pkg::ST_PRE:
					begin
						tgt = 2'h1; // see RULE_02
						if (out_q == 2'h1)
							cnt_d = cnt_q + 32'h0000_0001;
						if (cnt_q >= 32'(buck_pkg::PRECHG_CYC - 1))
						begin
							st_d = buck_pkg::ST_RUN;
							avg_d = 6'h00;
						end
					end
					buck_pkg::ST_RUN:
					begin
						hs_want = c.pwm_req && !pk_q;
						// Not switching and bootstrap low: refresh
						if (ref_q == 8'h00 && c.boot_low &&
							out_q != 2'h1)
							ref_d = 8'(buck_pkg::MIN_OFF_CYC); // see RULE_03
						// Overvoltage blocks the high side from its first
						// synchronised cycle, before the latch is set
						if (ref_q != 8'h00 || ov_q || c.over_114)
							hs_want = 1'b0; // see RULE_03 RULE_18
						// Negative limit turns the high side back on
						if (ng_q)
							hs_want = 1'b1; // see RULE_16 RULE_18
						tgt = {hs_want, !hs_want};
						// Run of consecutive over-average cycles
						if (gs2_q.cycle_tick)
							avg_d = c.avg_over ? avg_q + 6'h01 : 6'h00;
						if (c.second_peak_limit ||
							(hic_q && gs2_q.cycle_tick && c.avg_over &&
							avg_q == 6'(buck_pkg::AVG_TRIP_CNT - 1)))
						begin
							st_d = buck_pkg::ST_HIC; // see RULE_12 RULE_15
							cnt_d = 32'h0000_0000;
							tgt = 2'h0;
						end
					end
					buck_pkg::ST_HIC:
					begin
						// Both gates stay off while the timer runs
						cnt_d = cnt_q + 32'h0000_0001; // see RULE_21
						if (cnt_q == 32'(HICCUP_CYCLES - 1))
							st_d = buck_pkg::ST_INIT; // see RULE_22
					end
					default:
						st_d = buck_pkg::ST_OFF;
				endcase
				// Disable or supply loss wins over every state
				if (!en || !ready)
				begin
					st_d = buck_pkg::ST_OFF; // see RULE_07
					tgt = 2'h0;
				end
			end

			// Non-overlap: any change passes through both-off
			always_comb
			begin
				out_d = out_q;
				dead_d = (dead_q != 4'h0) ? dead_q - 4'h1 : dead_q;
				if (tgt != out_q)
				begin
					if (out_q != 2'h0)
					begin
						out_d = 2'h0;
						dead_d = 4'(buck_pkg::DEAD_CYC); // see RULE_01
					end
					else if (dead_q == 4'h0)
						out_d = tgt; // see RULE_01 RULE_02
				end
			end

			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					st_q <= buck_pkg::ST_OFF;
					cnt_q <= 32'h0000_0000;
					on_q <= 8'h00;
					ref_q <= 8'h00;
					dead_q <= 4'h0;
					avg_q <= 6'h00;
					out_q <= buck_pkg::GATES_RST;
					pk_q <= 1'b0;
					ng_q <= 1'b0;
					ov_q <= 1'b0;
				end
				else
				begin
					st_q <= st_d;
					cnt_q <= cnt_d;
					on_q <= on_d;
					ref_q <= ref_d;
					dead_q <= dead_d;
					avg_q <= avg_d;
					out_q <= out_d;
					pk_q <= pk_d;
					ng_q <= ng_d;
					ov_q <= ov_d;
				end
			end

			// Gate outputs straight from the pattern register
			assign upper_switch_drive[ch] = out_q[1];
			assign lower_switch_drive[ch] = out_q[0];
		end
	endgenerate

endmodule : buck_gate_and_fault_supervisor

/* core/buck_pkg.sv */
// Shared types and timing constants for the buck gate and fault supervisor
package buck_pkg;
	// Clock period in ns
	localparam int CLK_NS = 8;
	// Switch non-overlap time
	localparam int DEAD_NS = 20;
	localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	// Least high-side on time (blanking), plain default
	localparam int MIN_ON_NS = 80;
	localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_NS - 1) / CLK_NS;
	// Bootstrap refresh pulse (minimum off time), plain default
	localparam int MIN_OFF_NS = 200;
	localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
	// Start-up low-side precharge time, plain default
	localparam int PRECHG_NS = 400;
	localparam int PRECHG_CYC = (PRECHG_NS + CLK_NS - 1) / CLK_NS;
	// Power-good qualification time
	localparam int PG_US = 1100;
	localparam int PG_CYC = PG_US * 1000 / CLK_NS;
	// Hiccup off time
	localparam int HICCUP_US = 55000;
	localparam int HICCUP_CYC = HICCUP_US * 1000 / CLK_NS;
	// Consecutive over-average switching cycles before hiccup
	localparam int AVG_TRIP_CNT = 32;
	// Reset values
	localparam logic [1:0] GATES_RST = 2'h0;
	localparam logic MODE_HIC_RST = 1'h0;

	// Channel sequencing states, Gray along the usual path
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_INIT = 3'h1,
		ST_PRE = 3'h3,
		ST_RUN = 3'h2,
		ST_HIC = 3'h6
	} state_e;

	// Digitised comparator results of one channel
	typedef struct packed {
		logic pwm_req;
		logic first_peak_limit;
		logic second_peak_limit;
		logic negative_peak_limit;
		logic avg_over;
		logic boot_low;
		logic over_114;
		logic at_nominal;
	} chan_cmp_s;

	// Chip-level comparator and pin results
	typedef struct packed {
		logic input_undervolt_lockout;
		logic rail_above_4v;
		logic rail_above_3v5;
		logic lowside2_current_mode_pin;
		logic ch1_feedback;
		logic ch1_enable_in;
		logic ch2_enable_in;
		logic cycle_tick;
	} glob_cmp_s;
endpackage : buck_pkg

/* verif/buck_sup_props_properties.sv */
// Port assertions for the buck gate and fault supervisor
`timescale 1ns/1ns
module buck_sup_props #(
	parameter int HICCUP_CYCLES = 200,
	parameter int PG_CYCLES = 50
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Design inputs and outputs
	input buck_pkg::glob_cmp_s glob_in,
	input buck_pkg::chan_cmp_s [1:0] chan_in,
	input wire logic [1:0] upper_switch_drive,
	input wire logic [1:0] lower_switch_drive,
	input wire logic power_good_out,
	input wire logic excess_output_flag,
	input wire logic ocp_hiccup_mode
);
	wire [1:0] hi = upper_switch_drive;
	wire [1:0] lo = lower_switch_drive;
	int run_d;
	int run_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// Length of the present run of channel 1 good at the pins
	always_comb
		run_d = glob_in.ch1_feedback && glob_in.ch1_enable_in ? run_q + 1 : 0;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			run_q <= 0;
		else
			run_q <= run_d;
	property p_dead_lh;
		$fell(lo[0]) |-> !hi[0] [*3];
	endproperty
	a_dead_lh: assert property (p_dead_lh) else $error("gap");
	property p_dead_hl;
		$fell(hi[0]) |-> !lo[0] [*3];
	endproperty
	a_dead_hl: assert property (p_dead_hl) else $error("gap");
	property p_excl;
		(hi & lo) == 2'h0;
	endproperty
	a_excl: assert property (p_excl) else $error("overlap");
	property p_pg_rise;
		$rose(power_good_out) |-> run_q >= PG_CYCLES;
	endproperty
	a_pg_rise: assert property (p_pg_rise) else $error("pg early");
	property p_pg_drop;
		!(glob_in.ch1_feedback && glob_in.ch1_enable_in) |->
			##[1:4] !power_good_out;
	endproperty
	a_pg_drop: assert property (p_pg_drop) else $error("pg late");
	property p_input_undervolt_lockout;
		glob_in.input_undervolt_lockout [*7] |->
			hi == 2'h0 && lo == 2'h0 && !power_good_out;
	endproperty
	a_input_undervolt_lockout: assert property (p_input_undervolt_lockout) else $error("not held");
	property p_ov_flag;
		(chan_in[1].over_114 && glob_in.ch2_enable_in && glob_in.rail_above_4v
			&& !glob_in.input_undervolt_lockout) [*4] |->
			##[0:4] excess_output_flag;
	endproperty
	a_ov_flag: assert property (p_ov_flag) else $error("no flag");
	property p_mode;
		$rose(ocp_hiccup_mode) |-> !$past(glob_in.lowside2_current_mode_pin, 3);
	endproperty
	a_mode: assert property (p_mode) else $error("bad mode");
	// Main scenarios reached
	c_pg: cover property ($rose(power_good_out));
	c_ov: cover property ($rose(excess_output_flag));
	c_cc: cover property ($fell(ocp_hiccup_mode));
endmodule : buck_sup_props

/* verif/bridge_model.sv */
// Half-bridge and bootstrap capacitor model for both channels
`timescale 1ns/1ns
module bridge_model (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Gate commands and bootstrap droop flags
	input wire logic [1:0] upper,
	input wire logic [1:0] lower,
	output logic [1:0] boot_low
);
	localparam int DROOP = 150;
	int age [2];
	// Capacitor droops while the low side stays off
	always @(posedge clk or negedge resetn)
		for (int i = 0; i < 2; i++)
			age[i] <= (!resetn || lower[i]) ? 0 : age[i] + 1;
	assign boot_low = {age[1] >= DROOP, age[0] >= DROOP};
endmodule : bridge_model

/* verif/tb_buck_gate_and_fault_supervisor.sv */
// Directed bench for the buck gate and fault supervisor
`timescale 1ns/1ns
module tb_buck_gate_and_fault_supervisor;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	buck_pkg::glob_cmp_s g = 8'h6e;
	buck_pkg::chan_cmp_s [1:0] c = 16'h0101;
	buck_pkg::chan_cmp_s [1:0] cw;
	logic [1:0] bl;
	logic [1:0] up;
	logic [1:0] lo;
	logic pg;
	logic ov;
	logic mode;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	// Bootstrap droop joins the comparator flags
	assign cw = c | {5'h0, bl[1], 2'h0, 5'h0, bl[0], 2'h0};
	buck_gate_and_fault_supervisor #(.HICCUP_CYCLES(200), .PG_CYCLES(50)) DUT (
		.clk(clk), .resetn(resetn), .glob_in(g), .chan_in(cw),
		.upper_switch_drive(up), .lower_switch_drive(lo),
		.power_good_out(pg), .excess_output_flag(ov), .ocp_hiccup_mode(mode));
	bridge_model fets (.clk(clk), .resetn(resetn), .upper(up), .lower(lo),
		.boot_low(bl));
	always #4 clk = ~clk;
	// Ceiling on run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			final_report();
		end
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask : tk
	// Compare, then realign to the clock
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
		@(posedge clk);
	endtask : chk
	task automatic wait_on(input logic [3:0] sel);
		for (int i = 0; i < 400 && !({up, lo} & sel); i++)
			@(posedge clk);
	endtask : wait_on
	// Channel stays dark through the hiccup wait, then restarts
	task automatic restart(input int ch);
		tk(5);
		#1 chk({up[ch], lo[ch]}, 8'h00);
		tk(190);
		#1 chk({up[ch], lo[ch]}, 8'h00);
		wait_on(4'h1 << ch);
		#1 chk({up[ch], lo[ch]}, 8'h01);
	endtask : restart
	task automatic final_report();
		$display("n_fail=%0d checks=%0d", n_fail, checks);
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	// Directed sequence
	initial
	begin
		tk(4);
		resetn <= 1'h1;
		wait_on(4'h5);
		#1 chk({up[0], lo[0]}, 8'h01);
		tk(30);
		#1 chk(pg, 8'h00);
		c[0].pwm_req <= 1'h1;
		tk(30);
		#1 chk({pg, mode, up[0], lo[0]}, 8'h0e);
		for (int i = 2; i < 4; i++)
		begin
			g[i] <= 1'h0;
			tk(4);
			#1 chk(pg, 8'h00);
			g[i] <= 1'h1;
			tk(60);
			#1 chk(pg, 8'h01);
		end
		c[0].first_peak_limit <= 1'h1;
		tk(5);
		#1 chk(up[0], 8'h00);
		c[0].pwm_req <= 1'h0;
		tk(6);
		c[0].pwm_req <= 1'h1;
		wait_on(4'h4);
		tk(7);
		#1 chk(up[0], 8'h01);
		c[0] <= 8'h01;
		tk(4);
		c[0] <= 8'h81;
		wait_on(4'h4);
		wait_on(4'h1);
		#1 chk({up[0], lo[0]}, 8'h01);
		tk(40);
		#1 chk({up[0], lo[0]}, 8'h02);
		c[1] <= 8'h82;
		tk(6);
		#1 chk({ov, up[1], lo[1]}, 8'h05);
		c[1] <= 8'h92;
		tk(10);
		#1 chk({up[1], lo[1]}, 8'h02);
		c[1] <= 8'h81;
		// Tick ends the negative cut so the check sees plain PWM
		g.cycle_tick <= 1'h1;
		tk(1);
		g.cycle_tick <= 1'h0;
		tk(7);
		#1 chk({ov, up[1], lo[1]}, 8'h02);
		c[0].avg_over <= 1'h1;
		for (int i = 0; i < 32; i++)
		begin
			// Still running after 31 ticks: the trip needs all 32
			if (i == 31)
				#1 chk(up[0] | lo[0], 8'h01);
			g.cycle_tick <= 1'h1;
			tk(1);
			g.cycle_tick <= 1'h0;
			tk(3);
		end
		c[0].avg_over <= 1'h0;
		restart(0);
		c[1].second_peak_limit <= 1'h1;
		tk(1);
		c[1].second_peak_limit <= 1'h0;
		restart(1);
		g.lowside2_current_mode_pin <= 1'h1;
		tk(6);
		#1 chk(mode, 8'h01);
		g.input_undervolt_lockout <= 1'h1;
		tk(6);
		#1 chk({pg, up, lo}, 8'h00);
		g <= 8'h1e;
		tk(6);
		g <= 8'h3e;
		tk(20);
		#1 chk({up, lo}, 8'h00);
		g <= 8'h7e;
		wait_on(4'h1);
		g <= 8'h3e;
		tk(70);
		#1 chk({mode, up[0], lo[0]}, 8'h02);
		final_report();
	end
endmodule : tb_buck_gate_and_fault_supervisor
bind buck_gate_and_fault_supervisor buck_sup_props #(
	.HICCUP_CYCLES(HICCUP_CYCLES), .PG_CYCLES(PG_CYCLES)) props (
	.clk(clk), .resetn(resetn), .glob_in(glob_in), .chan_in(chan_in),
	.upper_switch_drive(upper_switch_drive),
	.lower_switch_drive(lower_switch_drive),
	.power_good_out(power_good_out), .excess_output_flag(excess_output_flag),
	.ocp_hiccup_mode(ocp_hiccup_mode));
